// *** hw/shared_gpio_port_lcd_segments.sv ***
// axi4-lite gpio ports c and e with lcd segment, timer and standby sharing
//
// Summary of operation
// [RULE_01] direction bit 1 makes pin an output
// [RULE_02] output pin drives its latch bit
// [RULE_03] data write updates latch and output pins
// [RULE_04] output pin read returns latch bit
// [RULE_05] direction bit 0 makes pin an input
// [RULE_06] input pin write stores latch only
// [RULE_07] input read gives pad, rmw gives latch
// [RULE_08] data bit 0 low, 1 high
// [RULE_09] software disables other drivers before port use
// [RULE_10] select 0 then input control 1 gives port
// [RULE_11] direction 0, select 1, control 1 gives lcd
// [RULE_12] reset clears all direction bits
// [RULE_13] float setting plus standby forces high impedance
// [RULE_14] forced standby holds internal input low
// [RULE_15] float setting 0 keeps pins in standby
// [RULE_16] port c uses bits 0 to 3
// [RULE_17] port e has same register behaviour
// [RULE_18] port e pins 5,6,7 serve timer one
// [RULE_19] peripheral driven pin reads pad, rmw latch
// [RULE_20] port c upper bits read zero, ignored
`timescale 1ns/100ps

module shared_gpio_port_lcd_segments
   import gpio_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic [C_W-1:0]    portCPadIn,
   output logic [C_W-1:0]         portCPadOut,
   output logic [C_W-1:0]         portCPadOeN,
   input  wire logic [E_W-1:0]    portEPadIn,
   output logic [E_W-1:0]         portEPadOut,
   output logic [E_W-1:0]         portEPadOeN,
   input  wire logic [C_W-1:0]    lcdSegC,
   input  wire logic [E_W-1:0]    lcdSegE,
   input  wire logic              timer1OutputA,
   input  wire logic              timer1OutputAEn,
   input  wire logic              timer1OutputB,
   input  wire logic              timer1OutputBEn,
   input  wire logic              standbyEntered,
   output logic                   timer1ExternalClock
);

   gpio_state_type stateReg;
   gpio_state_type stateNext;

   logic           forced;
   logic [C_W-1:0] cInGated;
   logic [E_W-1:0] eInGated;
   logic [C_W-1:0] cPortOut;
   logic [E_W-1:0] ePortOut;
   logic [C_W-1:0] cPeriph;
   logic [E_W-1:0] ePeriph;
   logic [E_W-1:0] eTmrEn;
   logic [E_W-1:0] eTmrVal;
   logic [C_W-1:0] cLcdOwn;
   logic [E_W-1:0] eLcdOwn;
   logic [C_W-1:0] cRead;
   logic [E_W-1:0] eRead;
   logic [DATA_W-1:0] rdMux;
   logic              rdHit;
   logic              wrHit;

   // standby float: all pins released, input path held low
   assign forced = stateReg.pinFloat & standbyEntered; // [RULE_13] [RULE_15]

   always_comb begin
      cInGated = portCPadIn & {C_W{~forced}}; // [RULE_14]
      eInGated = portEPadIn & {E_W{~forced}}; // [RULE_14]
   end

   // timer one outputs on port e
   always_comb begin
      eTmrEn = '0;
      eTmrVal = '0;
      eTmrEn[TMR_OUT_A_BIT] = timer1OutputAEn; // [RULE_18]
      eTmrVal[TMR_OUT_A_BIT] = timer1OutputA;
      eTmrEn[TMR_OUT_B_BIT] = timer1OutputBEn; // [RULE_18]
      eTmrVal[TMR_OUT_B_BIT] = timer1OutputB;
   end

   // ownership of each pin by current register contents and timer enables
   always_comb begin
      cLcdOwn = stateReg.cSeg & {C_W{stateReg.inCtl}}; // [RULE_11]
      eLcdOwn = stateReg.eSeg & {E_W{stateReg.inCtl}}; // [RULE_11]
      // port mode needs select 0 and input control 1
      cPortOut = stateReg.cDir & ~stateReg.cSeg & {C_W{stateReg.inCtl}}; // [RULE_01] [RULE_10]
      ePortOut = stateReg.eDir & ~stateReg.eSeg & {E_W{stateReg.inCtl}}; // [RULE_01] [RULE_10] [RULE_17]
      cPeriph = cLcdOwn;
      ePeriph = eLcdOwn | (eTmrEn & ~eLcdOwn);
   end

   // ordinary read view: latch for port outputs, pad otherwise
   // pins taken by a peripheral always read back their pad
   always_comb begin
      cRead = (stateReg.cLatch & cPortOut & ~cPeriph)
            | (cInGated & ~(cPortOut & ~cPeriph)); // [RULE_04] [RULE_07]
      eRead = (stateReg.eLatch & ePortOut & ~ePeriph)
            | (eInGated & ~(ePortOut & ~ePeriph)); // [RULE_17] [RULE_19]
   end

   // read decode
   always_comb begin
      rdMux = '0;
      rdHit = 1'b1;
      if (araddr == OFS_C_LATCH) begin
         rdMux[C_W-1:0] = cRead; // [RULE_08] [RULE_16] [RULE_20]
      end else if (araddr == OFS_C_DIR) begin
         rdMux[C_W-1:0] = stateReg.cDir; // [RULE_20]
      end else if (araddr == OFS_E_LATCH) begin
         rdMux[E_W-1:0] = eRead; // [RULE_08]
      end else if (araddr == OFS_E_DIR) begin
         rdMux[E_W-1:0] = stateReg.eDir;
      end else if (araddr == OFS_CTRL) begin
         rdMux[CTRL_CSEG_LSB +: C_W] = stateReg.cSeg;
         rdMux[CTRL_ESEG_LSB +: E_W] = stateReg.eSeg;
         rdMux[CTRL_INCTL] = stateReg.inCtl;
         rdMux[CTRL_FLOAT] = stateReg.pinFloat;
      end else if (araddr == OFS_STATUS) begin
         rdMux[STAT_FORCED] = forced;
         rdMux[STAT_STANDBY] = standbyEntered;
      end else if (araddr == OFS_C_RMW) begin
         // read half of a read-modify-write sees the latch
         rdMux[C_W-1:0] = stateReg.cLatch; // [RULE_07] [RULE_20]
      end else if (araddr == OFS_E_RMW) begin
         rdMux[E_W-1:0] = stateReg.eLatch; // [RULE_07] [RULE_19]
      end else begin
         rdHit = 1'b0;
      end
   end

   // write address hit check
   always_comb begin
      wrHit = 1'b1;
      if (stateReg.awAddr == OFS_C_LATCH) begin
         wrHit = 1'b1;
      end else if (stateReg.awAddr == OFS_C_DIR) begin
         wrHit = 1'b1;
      end else if (stateReg.awAddr == OFS_E_LATCH) begin
         wrHit = 1'b1;
      end else if (stateReg.awAddr == OFS_E_DIR) begin
         wrHit = 1'b1;
      end else if (stateReg.awAddr == OFS_CTRL) begin
         wrHit = 1'b1;
      end else begin
         wrHit = 1'b0;
      end
   end

   always_comb begin
      stateNext = stateReg;

      // write address channel
      if (stateReg.awReady && awvalid) begin
         stateNext.awHeld = 1'b1;
         stateNext.awAddr = awaddr;
         stateNext.awReady = 1'b0;
      end

      // write data channel
      if (stateReg.wReady && wvalid) begin
         stateNext.wHeld = 1'b1;
         stateNext.wData = wdata;
         stateNext.wStrb = wstrb;
         stateNext.wReady = 1'b0;
      end

      // both halves present: commit the write
      if (stateReg.awHeld && stateReg.wHeld && !stateReg.bValid) begin
         stateNext.awHeld = 1'b0;
         stateNext.wHeld = 1'b0;
         stateNext.bValid = 1'b1;
         stateNext.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
         if (stateReg.wStrb[0]) begin
            if (stateReg.awAddr == OFS_C_LATCH) begin
               // latch always stored, pin follows only if output
               stateNext.cLatch = stateReg.wData[C_W-1:0]; // [RULE_03] [RULE_06] [RULE_20]
            end else if (stateReg.awAddr == OFS_C_DIR) begin
               stateNext.cDir = stateReg.wData[C_W-1:0]; // [RULE_01] [RULE_05] [RULE_20]
            end else if (stateReg.awAddr == OFS_E_LATCH) begin
               stateNext.eLatch = stateReg.wData[E_W-1:0]; // [RULE_03] [RULE_06] [RULE_17]
            end else if (stateReg.awAddr == OFS_E_DIR) begin
               stateNext.eDir = stateReg.wData[E_W-1:0]; // [RULE_17]
            end else if (stateReg.awAddr == OFS_CTRL) begin
               stateNext.cSeg = stateReg.wData[CTRL_CSEG_LSB +: C_W];
               stateNext.inCtl = stateReg.wData[CTRL_INCTL];
               stateNext.pinFloat = stateReg.wData[CTRL_FLOAT];
            end
         end
         // eseg sits in byte lanes 0 and 1
         if (stateReg.awAddr == OFS_CTRL) begin
            if (stateReg.wStrb[1]) begin
               stateNext.eSeg[E_W-1:E_W-C_W] = stateReg.wData[CTRL_ESEG_LSB+C_W +: C_W];
            end
            if (stateReg.wStrb[0]) begin
               stateNext.eSeg[C_W-1:0] = stateReg.wData[CTRL_ESEG_LSB +: C_W];
            end
            if (!stateReg.wStrb[2]) begin
               stateNext.inCtl = stateReg.inCtl;
               stateNext.pinFloat = stateReg.pinFloat;
            end
         end
      end

      // write response
      if (stateReg.bValid && bready) begin
         stateNext.bValid = 1'b0;
         stateNext.awReady = 1'b1;
         stateNext.wReady = 1'b1;
      end

      // read channel
      if (stateReg.arReady && arvalid) begin
         stateNext.arReady = 1'b0;
         stateNext.rValid = 1'b1;
         stateNext.rData = rdMux;
         stateNext.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (stateReg.rValid && rready) begin
         stateNext.rValid = 1'b0;
         stateNext.arReady = 1'b1;
      end

      // port c pad drivers, low enable means driving
      for (int i = 0; i < C_W; i++) begin
         if (forced) begin
            stateNext.cOeN[i] = 1'b1; // [RULE_13]
            stateNext.cOut[i] = 1'b0;
         end else if (cLcdOwn[i]) begin
            stateNext.cOeN[i] = 1'b0; // [RULE_11]
            stateNext.cOut[i] = lcdSegC[i];
         end else if (cPortOut[i]) begin
            stateNext.cOeN[i] = 1'b0; // [RULE_01] [RULE_02] [RULE_15]
            stateNext.cOut[i] = stateNext.cLatch[i]; // [RULE_03] [RULE_08]
         end else begin
            stateNext.cOeN[i] = 1'b1; // [RULE_05] [RULE_06]
            stateNext.cOut[i] = 1'b0;
         end
      end

      // port e pad drivers; lcd beats timer beats port
      for (int i = 0; i < E_W; i++) begin
         if (forced) begin
            stateNext.eOeN[i] = 1'b1; // [RULE_13]
            stateNext.eOut[i] = 1'b0;
         end else if (eLcdOwn[i]) begin
            stateNext.eOeN[i] = 1'b0; // [RULE_11]
            stateNext.eOut[i] = lcdSegE[i];
         end else if (eTmrEn[i]) begin
            // timer output wins over port drive; lcd select must be cleared by software
            stateNext.eOeN[i] = 1'b0; // [RULE_09] [RULE_18]
            stateNext.eOut[i] = eTmrVal[i];
         end else if (ePortOut[i]) begin
            stateNext.eOeN[i] = 1'b0; // [RULE_02] [RULE_17] [RULE_15]
            stateNext.eOut[i] = stateNext.eLatch[i]; // [RULE_03] [RULE_08]
         end else begin
            stateNext.eOeN[i] = 1'b1; // [RULE_05]
            stateNext.eOut[i] = 1'b0;
         end
      end

      // external clock input of timer one, gated in forced standby
      stateNext.tmrClk = eInGated[TMR_CLK_BIT]; // [RULE_18] [RULE_14]
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stateReg <= STATE_RST; // [RULE_12]
      end else begin
         stateReg <= stateNext;
      end
   end

   assign awready = stateReg.awReady;
   assign wready = stateReg.wReady;
   assign bvalid = stateReg.bValid;
   assign bresp = stateReg.bResp;
   assign arready = stateReg.arReady;
   assign rvalid = stateReg.rValid;
   assign rdata = stateReg.rData;
   assign rresp = stateReg.rResp;
   assign portCPadOut = stateReg.cOut;
   assign portCPadOeN = stateReg.cOeN;
   assign portEPadOut = stateReg.eOut;
   assign portEPadOeN = stateReg.eOeN;
   assign timer1ExternalClock = stateReg.tmrClk;

endmodule

// *** pkg/gpio_pkg.sv ***
// constants, register map and state record for the shared gpio ports
package gpio_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int C_W    = 4;
   localparam int E_W    = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_C_LATCH = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_C_DIR   = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_E_LATCH = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_E_DIR   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_C_RMW   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_E_RMW   = 8'h1c;

   // control register fields
   localparam int CTRL_CSEG_LSB = 0;
   localparam int CTRL_ESEG_LSB = 4;
   localparam int CTRL_INCTL    = 16;
   localparam int CTRL_FLOAT    = 17;

   // status register fields
   localparam int STAT_FORCED  = 0;
   localparam int STAT_STANDBY = 1;

   // port e pins shared with the composite timer
   localparam int TMR_OUT_B_BIT = 5;
   localparam int TMR_OUT_A_BIT = 6;
   localparam int TMR_CLK_BIT   = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [C_W-1:0]    cLatch;
      logic [C_W-1:0]    cDir;
      logic [E_W-1:0]    eLatch;
      logic [E_W-1:0]    eDir;
      logic [C_W-1:0]    cSeg;
      logic [E_W-1:0]    eSeg;
      logic              inCtl;
      logic              pinFloat;
      logic              awReady;
      logic              wReady;
      logic              arReady;
      logic              awHeld;
      logic              wHeld;
      logic [ADDR_W-1:0] awAddr;
      logic [DATA_W-1:0] wData;
      logic [3:0]        wStrb;
      logic              bValid;
      logic [1:0]        bResp;
      logic              rValid;
      logic [1:0]        rResp;
      logic [DATA_W-1:0] rData;
      logic [C_W-1:0]    cOut;
      logic [C_W-1:0]    cOeN;
      logic [E_W-1:0]    eOut;
      logic [E_W-1:0]    eOeN;
      logic              tmrClk;
   } gpio_state_type;

   localparam gpio_state_type STATE_RST = '{
      awReady  : 1'b1,
      wReady   : 1'b1,
      arReady  : 1'b1,
      inCtl    : 1'b1,
      cOeN     : 4'hf,
      eOeN     : 8'hff,
      default  : 0
   };

endpackage

// *** tb/gpio_checker_assertions.sv ***
// concurrent checks on bus handshakes, reset state and timer pin sharing
`timescale 1ns/100ps
module gpio_checker
   import gpio_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         rst_n,
   input wire logic         awvalid,
   input wire logic         awready,
   input wire logic         wvalid,
   input wire logic         wready,
   input wire logic         bvalid,
   input wire logic         bready,
   input wire logic         arvalid,
   input wire logic         arready,
   input wire logic         rvalid,
   input wire logic         rready,
   input wire logic [31:0]  rdata,
   input wire logic [1:0]   rresp,
   input wire logic [3:0]   portCPadOeN,
   input wire logic [7:0]   portEPadIn,
   input wire logic [7:0]   portEPadOut,
   input wire logic [7:0]   portEPadOeN,
   input wire logic [7:0]   lcdSegE,
   input wire logic         timer1OutputB,
   input wire logic         timer1OutputBEn,
   input wire logic         timer1ExternalClock
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_bothTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_readTaken;
      arvalid && arready;
   endsequence

   property p_resetRelease;
      $rose(rst_n) |-> portCPadOeN == 4'hf && portEPadOeN == 8'hff;
   endproperty
   a_resetRelease: assert property (p_resetRelease) else $error("pins driven after reset");
   property p_writeAnswer;
      s_bothTaken |-> ##2 bvalid;
   endproperty
   a_writeAnswer: assert property (p_writeAnswer) else $error("write response late");
   property p_readAnswer;
      s_readTaken |=> rvalid;
   endproperty
   a_readAnswer: assert property (p_readAnswer) else $error("read response late");
   property p_bDrop;
      $fell(bvalid) |-> $past(bready);
   endproperty
   a_bDrop: assert property (p_bDrop) else $error("write response withdrawn");
   property p_rDrop;
      $fell(rvalid) |-> $past(rready);
   endproperty
   a_rDrop: assert property (p_rDrop) else $error("read response withdrawn");
   property p_busyWrite;
      bvalid |-> !awready && !wready;
   endproperty
   a_busyWrite: assert property (p_busyWrite) else $error("write accepted while answering");
   property p_errZero;
      rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0;
   endproperty
   a_errZero: assert property (p_errZero) else $error("error read carries data");
   property p_timerClk;
      timer1ExternalClock |-> $past(portEPadIn[7]);
   endproperty
   a_timerClk: assert property (p_timerClk) else $error("timer clock without pad level");
   property p_timerOut;
      $past(timer1OutputBEn) && !portEPadOeN[5] |->
         portEPadOut[5] == $past(timer1OutputB) || portEPadOut[5] == $past(lcdSegE[5]);
   endproperty
   a_timerOut: assert property (p_timerOut) else $error("timer output not on pin");
endmodule

bind shared_gpio_port_lcd_segments gpio_checker chk_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .portCPadOeN(portCPadOeN),
   .portEPadIn(portEPadIn), .portEPadOut(portEPadOut), .portEPadOeN(portEPadOeN), .lcdSegE(lcdSegE),
   .timer1OutputB(timer1OutputB), .timer1OutputBEn(timer1OutputBEn),
   .timer1ExternalClock(timer1ExternalClock)
);

// *** tb/pad_partner.sv ***
// external pin model: resolves each pad from port drive and outside level
`timescale 1ns/100ps
module pad_partner #(
   parameter int W = 4
) (
   input  wire logic [W-1:0] padOut,
   input  wire logic [W-1:0] padOeN,
   input  wire logic [W-1:0] extLevel,
   output logic      [W-1:0] padLevel
);
   // outside source yields wherever the port drives
   assign padLevel = (padOut & ~padOeN) | (extLevel & padOeN);
endmodule

// *** tb/test_shared_gpio_port_lcd_segments.sv ***
// self-checking bench for the shared gpio ports
`timescale 1ns/100ps
module test_shared_gpio_port_lcd_segments
   import gpio_pkg::*;
   ;
   logic        ref_clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, tBEn = 1'b0, tB = 1'b0, standby = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tmrClk;
   logic [1:0]  bresp, rresp;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, eExt = 8'h00, eOut, eOeN, eIn;
   logic [3:0]  wstrb = 4'hf, cExt = 4'ha, segC = 4'h0, cOut, cOeN, cIn;
   logic [31:0] wdata = 32'h0, rdata;
   int          error_cnt, samples_checked;

   shared_gpio_port_lcd_segments dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .portCPadIn(cIn), .portCPadOut(cOut),
      .portCPadOeN(cOeN), .portEPadIn(eIn), .portEPadOut(eOut), .portEPadOeN(eOeN), .lcdSegC(segC),
      .lcdSegE(8'h00), .timer1OutputA(tB), .timer1OutputAEn(tBEn), .timer1OutputB(tB),
      .timer1OutputBEn(tBEn), .standbyEntered(standby), .timer1ExternalClock(tmrClk));
   pad_partner #(.W(4)) padC (.padOut(cOut), .padOeN(cOeN), .extLevel(cExt), .padLevel(cIn));
   pad_partner #(.W(8)) padE (.padOut(eOut), .padOeN(eOeN), .extLevel(eExt), .padLevel(eIn));

   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic final_report();
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic bail(input int n);
      if (n >= 50) begin
         error_cnt++;
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      bail(n);
      chk("bresp", er, bresp);
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
      int n;
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      bail(n);
      chk("rdata", ex, rdata);
      chk("rresp", er, rresp);
   endtask

   task automatic tick();
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic s_reset();
      chk("cOeN", 4'hf, cOeN);
      chk("eOeN", 8'hff, eOeN);
      rd(OFS_C_DIR, 32'h0, RESP_OKAY);
      rd(OFS_E_DIR, 32'h0, RESP_OKAY);
      rd(OFS_CTRL, 32'h10000, RESP_OKAY);
   endtask

   task automatic s_port_c();
      wr(OFS_C_DIR, 32'hff, RESP_OKAY);
      rd(OFS_C_DIR, 32'hf, RESP_OKAY);
      wr(OFS_C_LATCH, 32'ha5, RESP_OKAY);
      chk("cOut", 4'h5, cOut);
      chk("cOeN", 4'h0, cOeN);
      rd(OFS_C_LATCH, 32'h5, RESP_OKAY);
      wr(OFS_C_DIR, 32'h0, RESP_OKAY);
      wr(OFS_C_LATCH, 32'h3, RESP_OKAY);
      chk("cOeN", 4'hf, cOeN);
      rd(OFS_C_LATCH, 32'ha, RESP_OKAY);
      rd(OFS_C_RMW, 32'h3, RESP_OKAY);
   endtask

   task automatic s_lcd();
      segC <= 4'h6;
      wr(OFS_CTRL, 32'hf, RESP_OKAY);
      chk("cOeN", 4'hf, cOeN);
      wr(OFS_CTRL, 32'h1000f, RESP_OKAY);
      chk("cOut", 4'h6, cOut);
      chk("cOeN", 4'h0, cOeN);
      rd(OFS_C_LATCH, 32'h6, RESP_OKAY);
      wr(OFS_CTRL, 32'h10000, RESP_OKAY);
      wr(OFS_C_DIR, 32'hf, RESP_OKAY);
      chk("cOut", 4'h3, cOut);
   endtask

   task automatic s_port_e();
      wr(OFS_E_DIR, 32'h7f, RESP_OKAY);
      wr(OFS_E_LATCH, 32'h3c, RESP_OKAY);
      chk("eOut", 8'h3c, eOut & 8'h7f);
      chk("eOeN", 8'h80, eOeN);
      eExt <= 8'h80;
      tBEn <= 1'b1;
      tick();
      chk("eOut5", 1'b0, eOut[5]);
      chk("eOut6", 1'b0, eOut[6]);
      chk("eOeN", 8'h80, eOeN);
      chk("tmrClk", 1'b1, tmrClk);
      rd(OFS_E_LATCH, 32'h9c, RESP_OKAY);
      rd(OFS_E_RMW, 32'h3c, RESP_OKAY);
   endtask

   task automatic s_standby();
      wr(OFS_CTRL, 32'h30000, RESP_OKAY);
      standby <= 1'b1;
      tick();
      chk("cOeN", 4'hf, cOeN);
      chk("eOeN", 8'hff, eOeN);
      chk("tmrClk", 1'b0, tmrClk);
      rd(OFS_STATUS, 32'h3, RESP_OKAY);
      wr(OFS_CTRL, 32'h10000, RESP_OKAY);
      chk("cOeN", 4'h0, cOeN);
      chk("cOut", 4'h3, cOut);
      standby <= 1'b0;
   endtask

   task automatic s_refused();
      wr(8'h20, 32'h1, RESP_SLVERR);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(OFS_STATUS, 32'h1, RESP_SLVERR);
      wr(OFS_C_RMW, 32'h0, RESP_SLVERR);
      rd(OFS_C_RMW, 32'h3, RESP_OKAY);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      s_reset();
      s_port_c();
      s_lcd();
      s_port_e();
      s_standby();
      s_refused();
      final_report();
   end
endmodule
